//--- pkg/lhims_defines.svh
// Functional notes
// - Straps 0000/0001/1000/1001 pick 6800-style bus
// - Straps 0010/0011/1010/1011 pick 8080-style bus
// - Straps 01xx pick RGB; 1110/1111 pick SPI
// - Nine-bit RGB at 65K ties D12 to D17
// - Register select low: index, high: control
`ifndef LHIMS_DEFINES_SVH
`define LHIMS_DEFINES_SVH
`define LHIMS_STRAP_W 4
`define LHIMS_DATA_W 18
`define LHIMS_FIFO_DEPTH 4
`define LHIMS_HV_MAX 320
`define LHIMS_RGB_LSB9 9
`define LHIMS_RGB_LSB6 12
`endif

//--- pkg/lhims_pkg.sv
package lhims_pkg;
  // Bus family chosen by straps
  typedef enum logic [2:0] {
    LHIMS_BUS_M68 = 3'h0,
    LHIMS_BUS_I80 = 3'h1,
    LHIMS_BUS_RGB = 3'h3,
    LHIMS_BUS_SPI = 3'h2,
    LHIMS_BUS_BAD = 3'h6
  } lhims_bus_e;
  // Decoded mode
  typedef struct packed {
    lhims_bus_e bus;
    logic [4:0] width;
    logic spi4;
  } lhims_mode_s;
  // Pixel word with its line/frame flags
  typedef struct packed {
    logic frame_start;
    logic line_start;
    logic [17:0] pixel;
  } lhims_pix_s;
endpackage : lhims_pkg

//--- hw/lhims_fifo.sv
`timescale 1ns/1ps
module lhims_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_reg];
  // Pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end
endmodule : lhims_fifo

//--- hw/lhims_top.sv
`timescale 1ns/1ps
`include "lhims_defines.svh"
module lhims_top import lhims_pkg::*; #(
  parameter int HV_MAX = `LHIMS_HV_MAX
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mode_strap_bit0,
  input wire logic mode_strap_bit1,
  input wire logic mode_strap_bit2,
  input wire logic mode_strap_bit3,
  input wire logic color_65k_i,
  input wire logic register_select_in,
  input wire logic pixel_clock_in,
  input wire logic line_sync_n_i,
  input wire logic frame_sync_n_i,
  input wire logic [17:0] data_bus_i,
  output lhims_mode_s mode_o,
  output logic reg_is_control_o,
  output logic sync_err_o,
  output lhims_pix_s pix_o,
  output logic pix_valid_o,
  input wire logic pix_ready_i,
  output logic overflow_o
);
  // ==========================================
  // Input synchronisers
  localparam int NS = 24;
  logic [NS-1:0] s1_reg;
  logic [NS-1:0] s2_reg;
  logic pclk_d_reg;
  wire [NS-1:0] raw = {mode_strap_bit3, mode_strap_bit2, mode_strap_bit1,
    mode_strap_bit0, register_select_in, pixel_clock_in, data_bus_i};
  // Two flops per strap, select, dot clock and data input
  always_ff @(posedge clk_i) begin
    s1_reg <= raw;
    s2_reg <= s1_reg;
    pclk_d_reg <= s2_reg[18];
  end
  // Syncs are stored apart from the bus to keep NS small
  logic [1:0] hs_reg;
  logic [1:0] vs_reg;
  logic hs_d_reg;
  logic vs_d_reg;
  always_ff @(posedge clk_i) begin
    hs_reg <= {hs_reg[0], line_sync_n_i};
    vs_reg <= {vs_reg[0], frame_sync_n_i};
  end
  wire [3:0] strap_s = s2_reg[23:20];
  wire [17:0] data_s = s2_reg[17:0];
  wire pclk_rise = s2_reg[18] && !pclk_d_reg;

  // ==========================================
  // Strap decode, caught after reset release
  lhims_mode_s mode_next;
  lhims_mode_s mode_reg;
  logic [1:0] settle_reg;
  always_comb begin
    mode_next = '{bus: LHIMS_BUS_BAD, width: 5'h00, spi4: 1'b0};
    case (strap_s)
      4'h0: mode_next = '{LHIMS_BUS_M68, 5'h10, 1'b0};
      4'h1: mode_next = '{LHIMS_BUS_M68, 5'h08, 1'b0};
      4'h8: mode_next = '{LHIMS_BUS_M68, 5'h12, 1'b0};
      4'h9: mode_next = '{LHIMS_BUS_M68, 5'h09, 1'b0};
      4'h2: mode_next = '{LHIMS_BUS_I80, 5'h10, 1'b0};
      4'h3: mode_next = '{LHIMS_BUS_I80, 5'h08, 1'b0};
      4'ha: mode_next = '{LHIMS_BUS_I80, 5'h12, 1'b0};
      4'hb: mode_next = '{LHIMS_BUS_I80, 5'h09, 1'b0};
      4'h4: mode_next = '{LHIMS_BUS_RGB, 5'h09, 1'b0};
      4'h5: mode_next = '{LHIMS_BUS_RGB, 5'h10, 1'b0};
      4'h6: mode_next = '{LHIMS_BUS_RGB, 5'h12, 1'b0};
      4'h7: mode_next = '{LHIMS_BUS_RGB, 5'h06, 1'b0};
      4'he: mode_next = '{LHIMS_BUS_SPI, 5'h01, 1'b0};
      4'hf: mode_next = '{LHIMS_BUS_SPI, 5'h01, 1'b1};
      default: mode_next = '{LHIMS_BUS_BAD, 5'h00, 1'b0};
    endcase
  end
  // Straps latched once synchroniser has settled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      settle_reg <= 2'h0;
      mode_reg <= '{LHIMS_BUS_BAD, 5'h00, 1'b0};
    end else if (settle_reg != 2'h3) begin
      settle_reg <= settle_reg + 2'h1;
      mode_reg <= mode_next;
    end
  end
  assign mode_o = mode_reg;
  wire rgb_on = (mode_reg.bus == LHIMS_BUS_RGB) && (settle_reg == 2'h3);

  // ==========================================
  // Register select
  logic rs_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rs_reg <= 1'b0;
    end else begin
      rs_reg <= s2_reg[19];
    end
  end
  assign reg_is_control_o = rs_reg;

  // ==========================================
  // RGB pixel capture on dot clock rising edges
  logic [17:0] pix_word;
  always_comb begin
    case (mode_reg.width)
      5'h09: begin
        pix_word = {9'h000, data_s[17:`LHIMS_RGB_LSB9]};
        if (color_65k_i) begin
          pix_word[3] = data_s[17]; // D12 follows D17
        end
      end
      5'h06: pix_word = {12'h000, data_s[17:`LHIMS_RGB_LSB6]};
      5'h10: pix_word = {2'h0, data_s[15:0]};
      default: pix_word = data_s;
    endcase
  end
  // Sync falling edges; the delayed copies reset to the idle high level
  wire hs_fall = hs_d_reg && !hs_reg[1];
  wire vs_fall = vs_d_reg && !vs_reg[1];
  logic [8:0] hv_cnt_reg;
  logic hv_wait_reg;
  logic err_reg;
  logic fl_reg;
  logic ll_reg;
  wire fifo_rdy;
  // Pixels are taken only in RGB mode once the straps have settled
  wire push = rgb_on && pclk_rise; // Needs running dot clock
  // Sync edge tracking and line-after-frame window check
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hs_d_reg <= 1'b1;
      vs_d_reg <= 1'b1;
      hv_cnt_reg <= 9'h000;
      hv_wait_reg <= 1'b0;
      err_reg <= 1'b0;
      fl_reg <= 1'b0;
      ll_reg <= 1'b0;
    end else begin
      hs_d_reg <= hs_reg[1];
      vs_d_reg <= vs_reg[1];
      if (vs_fall) begin
        // A line sync falling with the frame sync already meets the window
        hv_wait_reg <= !hs_fall;
        hv_cnt_reg <= 9'h000;
        fl_reg <= 1'b1;
      end else if (hv_wait_reg && hs_fall) begin
        hv_wait_reg <= 1'b0;
      end else if (hv_wait_reg && pclk_rise) begin
        if (hv_cnt_reg == 9'(HV_MAX)) begin
          err_reg <= 1'b1; // Host broke sync window
          hv_wait_reg <= 1'b0;
        end else begin
          hv_cnt_reg <= hv_cnt_reg + 9'h001;
        end
      end
      if (hs_fall) begin
        ll_reg <= 1'b1;
      end
      // The pushed pixel carries any pending flag, so both are spent here
      if (push) begin
        fl_reg <= 1'b0;
        ll_reg <= 1'b0;
      end
    end
  end
  assign sync_err_o = err_reg;
  logic ovf_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ovf_reg <= 1'b0;
    end else if (push && !fifo_rdy) begin
      ovf_reg <= 1'b1;
    end
  end
  assign overflow_o = ovf_reg;

  lhims_pix_s pix_in;
  logic [19:0] fifo_out;
  assign pix_in = '{frame_start: fl_reg || vs_fall,
    line_start: ll_reg || hs_fall, pixel: pix_word};
  // Four-word buffer decouples dot clock capture from the consumer
  lhims_fifo #(
    .WIDTH(20),
    .DEPTH(`LHIMS_FIFO_DEPTH)
  ) u_lhims_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(pix_in),
    .in_valid_i(push),
    .in_ready_o(fifo_rdy),
    .out_data_o(fifo_out),
    .out_valid_o(pix_valid_o),
    .out_ready_i(pix_ready_i)
  );
  assign pix_o = fifo_out;

  // ==========================================
  // Assertions
  AST_M68_8: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (settle_reg == 2'h3 && $past(strap_s) == 4'h1 && $past(settle_reg) == 2'h2)
      |-> (mode_reg.bus == LHIMS_BUS_M68 && mode_reg.width == 5'h08))
    else $error("8-bit 6800 strap misdecoded");
  AST_I80_18: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (settle_reg == 2'h2 && strap_s == 4'ha) ##1 1'b1
      |-> (mode_reg.bus == LHIMS_BUS_I80 && mode_reg.width == 5'h12))
    else $error("18-bit 8080 strap misdecoded");
  AST_SPI4: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (settle_reg == 2'h2 && strap_s == 4'hf) |=> mode_reg.spi4)
    else $error("4-wire SPI strap misdecoded");
  AST_TIE: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (mode_reg.width == 5'h09 && color_65k_i) |-> pix_word[3] == pix_word[8])
    else $error("D12 not tied to D17");
  AST_RS: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ##1 reg_is_control_o == $past(s2_reg[19]))
    else $error("Register select not followed");
  AST_PUSH: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (push && fifo_rdy) |=> pix_valid_o)
    else $error("Accepted pixel not offered");
endmodule : lhims_top

//--- bench/lhims_host_model.sv
`timescale 1ns/1ps
// ==========
// Host pixel source
module lhims_host_model (
  input wire logic clk_i,
  output logic pixel_clock_o,
  output logic line_sync_n_o,
  output logic frame_sync_n_o,
  output logic [17:0] data_o
);
  // Idle levels
  initial begin
    pixel_clock_o = 1'b0;
    line_sync_n_o = 1'b1;
    frame_sync_n_o = 1'b1;
    data_o = 18'h00000;
  end
  // One dot period of 8 clocks, data set while dot clock is low
  task dot(input logic [17:0] d);
    pixel_clock_o = 1'b0;
    data_o = d;
    repeat (4) @(negedge clk_i);
    pixel_clock_o = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask : dot
  // Frame: gap dots before line sync falls, then n pixels from base
  task frame(input int gap, input int n, input logic [17:0] base);
    int i;
    @(negedge clk_i);
    frame_sync_n_o = 1'b0;
    for (i = 0; i < gap; i++) begin
      dot(~base);
    end
    line_sync_n_o = 1'b0;
    for (i = 0; i < n; i++) begin
      dot(base + 18'(i));
    end
    pixel_clock_o = 1'b0;
    line_sync_n_o = 1'b1;
    frame_sync_n_o = 1'b1;
    data_o = ~data_o;
  endtask : frame
endmodule : lhims_host_model

//--- bench/tb_lhims_top.sv
`timescale 1ns/1ps
// ==========
// Bench for mode straps and pixel path
module tb_lhims_top import lhims_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] strap = 4'h0;
  logic c65 = 1'b0;
  logic rs = 1'b0;
  logic rdy = 1'b0;
  logic pclk;
  logic ls_n;
  logic fs_n;
  logic [17:0] data;
  lhims_mode_s mode;
  lhims_pix_s pix;
  logic ctl;
  logic serr;
  logic pv;
  logic ovf;
  int err_count = 0;
  int comparisons = 0;
  // Clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Device and host
  lhims_top #(.HV_MAX(8)) u_lhims_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mode_strap_bit0(strap[0]), .mode_strap_bit1(strap[1]),
    .mode_strap_bit2(strap[2]), .mode_strap_bit3(strap[3]),
    .color_65k_i(c65), .register_select_in(rs), .pixel_clock_in(pclk),
    .line_sync_n_i(ls_n), .frame_sync_n_i(fs_n), .data_bus_i(data),
    .mode_o(mode), .reg_is_control_o(ctl), .sync_err_o(serr),
    .pix_o(pix), .pix_valid_o(pv), .pix_ready_i(rdy), .overflow_o(ovf));
  lhims_host_model u_lhims_host_model (.clk_i(clk_i), .pixel_clock_o(pclk),
    .line_sync_n_o(ls_n), .frame_sync_n_o(fs_n), .data_o(data));
  // Compare and count
  task chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  // Reset with the given straps, then let the mode settle
  task boot(input logic [3:0] s);
    strap = s;
    rst_n_i = 1'b0;
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask : boot
  // Wait for a pixel, compare it, then pop it
  task pop(input logic [17:0] e);
    int n;
    n = 0;
    while (pv !== 1'b1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    if (pv !== 1'b1) begin
      err_count++;
      $display("[FAIL] pixel valid expected 1 seen %b", pv);
      give_verdict;
    end else begin
      chk("pixel", e, pix.pixel);
      rdy = 1'b1;
      @(negedge clk_i);
      rdy = 1'b0;
    end
  endtask : pop
  // Expected bus family and width from the straps
  function automatic lhims_bus_e eb(input logic [3:0] s);
    if (s[3:2] == 2'b01) return LHIMS_BUS_RGB;
    if (s[3:1] == 3'b111) return LHIMS_BUS_SPI;
    if (s[3:2] == 2'b11) return LHIMS_BUS_BAD;
    return s[1] ? LHIMS_BUS_I80 : LHIMS_BUS_M68;
  endfunction : eb
  function automatic logic [4:0] ew(input logic [3:0] s);
    if (s[3:2] == 2'b01) return s[1] ? (s[0] ? 5'h06 : 5'h12)
                                     : (s[0] ? 5'h10 : 5'h09);
    return s[3] ? (s[0] ? 5'h09 : 5'h12) : (s[0] ? 5'h08 : 5'h10);
  endfunction : ew
  // Main sequence
  initial begin
    for (int k = 0; k < 16; k++) begin
      boot(4'(k));
      chk("bus", 18'(eb(4'(k))), 18'(mode.bus));
      if (k < 12) chk("width", 18'(ew(4'(k))), 18'(mode.width));
      if (k > 13) chk("spi4", 18'(k % 2), 18'(mode.spi4));
    end
    $display("test modes done");
    rs = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("select early", 18'h0, 18'(ctl));
    @(negedge clk_i);
    chk("select ctl", 18'h1, 18'(ctl));
    rs = 1'b0;
    repeat (3) @(negedge clk_i);
    chk("select idx", 18'h0, 18'(ctl));
    $display("test select done");
    boot(4'h0);
    u_lhims_host_model.frame(0, 2, 18'h2a5f0);
    repeat (4) @(negedge clk_i);
    chk("refused", 18'h0, 18'(pv));
    boot(4'h6);
    u_lhims_host_model.frame(0, 3, 18'h2a5f0);
    chk("frame start", 18'h1, 18'(pix.frame_start));
    chk("line start", 18'h1, 18'(pix.line_start));
    pop(18'h2a5f0);
    chk("frame mid", 18'h0, 18'(pix.frame_start));
    chk("line mid", 18'h0, 18'(pix.line_start));
    for (int k = 1; k < 3; k++) pop(18'h2a5f0 + 18'(k));
    chk("no overflow", 18'h0, 18'(ovf));
    u_lhims_host_model.frame(0, 6, 18'h15a00);
    repeat (2) @(negedge clk_i);
    chk("overflow", 18'h1, 18'(ovf));
    for (int k = 0; k < 4; k++) pop(18'h15a00 + 18'(k));
    chk("empty", 18'h0, 18'(pv));
    $display("test fifo done");
    boot(4'h4);
    c65 = 1'b1;
    u_lhims_host_model.frame(0, 1, 18'h20000);
    pop(18'h00108);
    c65 = 1'b0;
    u_lhims_host_model.frame(0, 1, 18'h20000);
    pop(18'h00100);
    $display("test nine bit done");
    boot(4'h6);
    u_lhims_host_model.frame(0, 10, 18'h00000);
    repeat (4) @(negedge clk_i);
    chk("sync zero", 18'h0, 18'(serr));
    u_lhims_host_model.frame(4, 1, 18'h00000);
    repeat (4) @(negedge clk_i);
    chk("sync ok", 18'h0, 18'(serr));
    u_lhims_host_model.frame(12, 1, 18'h00000);
    repeat (4) @(negedge clk_i);
    chk("sync late", 18'h1, 18'(serr));
    $display("test sync done");
    give_verdict;
  end
endmodule
